// ==== hw/power_clock_management.sv ====
`timescale 1ns/1ns
`default_nettype none
module power_clock_management #(
   parameter int unsigned WARMUP_CLKS = pwr_clk_pkg::WARMUP_CLKS
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        srst,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // interrupt level and serial activity
   input  wire logic [2:0]  level_active,
   input  wire logic [3:0]  port_busy,
   // wake, switchback and data-move events
   input  wire logic        irq_any,
   input  wire logic        ext_irq_wake,
   input  wire logic        powerfail_event,
   input  wire logic        ext_irq_valid,
   input  wire logic [1:0]  rx_start_bit,
   input  wire logic [1:0]  tx_buffer_write,
   input  wire logic        external_data_move,
   // clocking outputs
   output logic             cpu_cycle_en,
   output logic      [2:0]  timer_tick,
   output logic             cpu_clk_ring,
   output logic             crystal_amp_on,
   output logic             reference_on,
   output logic             cpu_halted,
   output logic             clocks_stopped,
   output logic             addr_strobe
);
   typedef struct packed {
      pwr_clk_pkg::mode_e mode;
      logic [1:0]         div_sel;
      logic               sw_en;
      logic               amp_off;
      logic               strobe_sup;
      logic               src_sel;
      logic               src_eff;
      logic               ring_hold;
      logic               ring_wake;
      logic               ref_stop;
      logic [2:0]         tmr_fast;
      logic               ack;
      logic [7:0]         rdata;
      logic [1:0]         strobe_cnt;
      logic               strobe;
   } state_s;

   state_s     r;
   state_s     n;
   cycle_if    cif ();
   logic       xtal_ready;
   logic       ring_flag;
   logic       wr;
   logic [7:0] idx;
   logic [7:0] wd;
   logic [7:0] rd_mux;
   logic       stop_wake;
   logic       switchback;
   logic [1:0] new_div;

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   cycle_divider u_div (
      .clk_sys (clk_sys),
      .srst    (srst),
      .cif     (cif)
   );

   // crystal is counted from the moment the amplifier runs again
   warmup_counter #(.LIMIT(WARMUP_CLKS)) u_warm (
      .clk_sys (clk_sys),
      .srst    (srst),
      .run     (crystal_amp_on),
      .ready   (xtal_ready)
   );

   assign idx        = wb_adr_i[9:2];
   assign wd         = wb_dat_i[7:0];
   assign wr         = wb_cyc_i && wb_stb_i && wb_we_i && r.ack && wb_sel_i[0];
   assign new_div    = wd[pwr_clk_pkg::POS_DIV_LO +: 2];
   assign ring_flag  = r.ring_hold || !r.src_eff;
   // internal interrupts need clocks, so only these can wake stop
   assign stop_wake  = ext_irq_wake || (powerfail_event && r.ref_stop);
   assign switchback = ext_irq_valid || (|rx_start_bit) || (|tx_buffer_write);

   // -------------------------------------------------------------
   // read mux
   // -------------------------------------------------------------
   always_comb begin
      rd_mux = 8'h00;
      case (idx)
         pwr_clk_pkg::IDX_POWER_CONTROL: begin
            rd_mux[pwr_clk_pkg::POS_IDLE] = (r.mode == pwr_clk_pkg::MODE_IDLE);
            rd_mux[pwr_clk_pkg::POS_STOP] = (r.mode == pwr_clk_pkg::MODE_STOP);
         end
         pwr_clk_pkg::IDX_CLOCK_CONTROL: begin
            rd_mux[pwr_clk_pkg::POS_TMR_LO +: 3] = r.tmr_fast;
         end
         pwr_clk_pkg::IDX_EXT_FLAGS: begin
            rd_mux[pwr_clk_pkg::POS_SRC_SEL]   = r.src_sel;
            rd_mux[pwr_clk_pkg::POS_RING_FLAG] = ring_flag;
            rd_mux[pwr_clk_pkg::POS_RING_WAKE] = r.ring_wake;
            rd_mux[pwr_clk_pkg::POS_REF_STOP]  = r.ref_stop;
         end
         pwr_clk_pkg::IDX_POWER_MANAGE: begin
            rd_mux[pwr_clk_pkg::POS_DIV_LO +: 2]  = r.div_sel;
            rd_mux[pwr_clk_pkg::POS_SW_EN]      = r.sw_en;
            rd_mux[pwr_clk_pkg::POS_AMP_OFF]    = r.amp_off;
            rd_mux[pwr_clk_pkg::POS_STROBE_SUP] = r.strobe_sup;
         end
         pwr_clk_pkg::IDX_STATUS: begin
            rd_mux[pwr_clk_pkg::POS_LEVEL_LO +: 3] = level_active;
            rd_mux[pwr_clk_pkg::POS_XTAL_READY]  = xtal_ready;
            rd_mux[3:0]                          = port_busy;
         end
         default: rd_mux = 8'h00;
      endcase
   end

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      n = r;
      n.ack   = wb_cyc_i && wb_stb_i && !r.ack;
      n.rdata = r.ack ? r.rdata : rd_mux;

      if (wr && idx == pwr_clk_pkg::IDX_CLOCK_CONTROL) begin
         n.tmr_fast = wd[pwr_clk_pkg::POS_TMR_LO +: 3];
      end
      if (wr && idx == pwr_clk_pkg::IDX_EXT_FLAGS) begin
         n.ring_wake = wd[pwr_clk_pkg::POS_RING_WAKE];
         n.ref_stop  = wd[pwr_clk_pkg::POS_REF_STOP];
         if (!(wd[pwr_clk_pkg::POS_SRC_SEL] && !r.src_sel && (!xtal_ready || r.amp_off))) begin
            n.src_sel = wd[pwr_clk_pkg::POS_SRC_SEL];
         end
      end
      if (wr && idx == pwr_clk_pkg::IDX_POWER_MANAGE) begin
         n.sw_en      = wd[pwr_clk_pkg::POS_SW_EN];
         n.strobe_sup = wd[pwr_clk_pkg::POS_STROBE_SUP];
         if (!(wd[pwr_clk_pkg::POS_AMP_OFF] && r.src_sel)) begin
            n.amp_off = wd[pwr_clk_pkg::POS_AMP_OFF];
         end
         // reserved code 00 is dropped, slow codes only from the 4-clock code
         if (new_div == pwr_clk_pkg::DIV_4 ||
             (r.div_sel == pwr_clk_pkg::DIV_4 && new_div != 2'h0)) begin
            n.div_sel = new_div;
         end
      end
      // hardware restore wins over a software write in the same cycle
      if (r.sw_en && switchback) begin
         n.div_sel = pwr_clk_pkg::DIV_4;
      end

      // source change also waits for a cycle boundary
      if (cif.cycle_en) begin
         n.src_eff = r.src_sel;
      end
      if (r.ring_hold && xtal_ready) begin
         n.ring_hold = 1'b0;
      end

      case (r.mode)
         pwr_clk_pkg::MODE_RUN: begin
            if (wr && idx == pwr_clk_pkg::IDX_POWER_CONTROL) begin
               if (wd[pwr_clk_pkg::POS_STOP]) begin
                  n.mode = pwr_clk_pkg::MODE_STOP;
               end else if (wd[pwr_clk_pkg::POS_IDLE]) begin
                  n.mode = pwr_clk_pkg::MODE_IDLE;
               end
            end
         end
         pwr_clk_pkg::MODE_IDLE: begin
            if (irq_any) begin
               n.mode = pwr_clk_pkg::MODE_RUN;
            end
         end
         pwr_clk_pkg::MODE_STOP: begin
            if (stop_wake) begin
               if (!r.src_eff || r.ring_wake) begin
                  n.mode      = pwr_clk_pkg::MODE_RUN;
                  n.ring_hold = r.src_eff && r.ring_wake;
               end else begin
                  n.mode = pwr_clk_pkg::MODE_WARM;
               end
            end
         end
         pwr_clk_pkg::MODE_WARM: begin
            if (xtal_ready) begin
               n.mode = pwr_clk_pkg::MODE_RUN;
            end
         end
         default: n.mode = pwr_clk_pkg::MODE_RUN;
      endcase

      n.strobe_cnt = (r.strobe_cnt == 2'(pwr_clk_pkg::STROBE_CLKS - 1))
                     ? 2'h0 : 2'(r.strobe_cnt + 2'h1);
      if (r.mode == pwr_clk_pkg::MODE_STOP || (r.strobe_sup && !external_data_move)) begin
         n.strobe = 1'b0;
      end else begin
         n.strobe = (n.strobe_cnt < 2'(pwr_clk_pkg::STROBE_CLKS / 2));
      end
   end

   // -------------------------------------------------------------
   // state register
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         r <= '{mode:       pwr_clk_pkg::MODE_RUN,
                div_sel:    pwr_clk_pkg::RST_DIV_SEL,
                sw_en:      pwr_clk_pkg::RST_CLEAR,
                amp_off:    pwr_clk_pkg::RST_CLEAR,
                strobe_sup: pwr_clk_pkg::RST_CLEAR,
                src_sel:    pwr_clk_pkg::RST_SRC_SEL,
                src_eff:    pwr_clk_pkg::RST_SRC_SEL,
                ring_hold:  pwr_clk_pkg::RST_CLEAR,
                ring_wake:  pwr_clk_pkg::RST_CLEAR,
                ref_stop:   pwr_clk_pkg::RST_CLEAR,
                tmr_fast:   3'h0,
                ack:        pwr_clk_pkg::RST_CLEAR,
                rdata:      8'h00,
                strobe_cnt: 2'h0,
                strobe:     pwr_clk_pkg::RST_CLEAR};
      end else begin
         r <= n;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign cif.div_sel  = r.div_sel;
   assign cif.tmr_fast = r.tmr_fast;
   // idle keeps timers going, stop and crystal warm-up freeze cycles and timers
   assign cif.hold     = (r.mode == pwr_clk_pkg::MODE_STOP) || (r.mode == pwr_clk_pkg::MODE_WARM);
   assign cpu_cycle_en = cif.cycle_en && (r.mode == pwr_clk_pkg::MODE_RUN);
   assign timer_tick   = cif.timer_tick;
   assign cpu_clk_ring = ring_flag;
   assign crystal_amp_on = !r.amp_off && (r.mode != pwr_clk_pkg::MODE_STOP);
   assign reference_on = (r.mode != pwr_clk_pkg::MODE_STOP) || r.ref_stop;
   assign cpu_halted   = (r.mode != pwr_clk_pkg::MODE_RUN);
   assign clocks_stopped = (r.mode == pwr_clk_pkg::MODE_STOP);
   assign addr_strobe  = r.strobe;
   assign wb_ack_o     = r.ack;
   assign wb_dat_o     = {24'h000000, r.rdata};

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   sequence s_ring_exit;
      r.mode == pwr_clk_pkg::MODE_STOP && stop_wake && r.ring_wake && r.src_eff;
   endsequence
   sequence s_ring_running;
      ring_flag && !cpu_halted ##1 ring_flag;
   endsequence

   a_reset_values: assert property (disable iff (1'b0) srst |=> !ring_flag && xtal_ready
      && r.div_sel == pwr_clk_pkg::DIV_4 && r.tmr_fast == 3'h0) else $error("bad reset state");
   a_src_guard: assert property (wr && idx == pwr_clk_pkg::IDX_EXT_FLAGS
      && wd[pwr_clk_pkg::POS_SRC_SEL] && !r.src_sel && (!xtal_ready || r.amp_off)
      |=> !r.src_sel) else $error("source switched to unready crystal");
   a_div_guard: assert property (wr && idx == pwr_clk_pkg::IDX_POWER_MANAGE && !switchback
      && r.div_sel != pwr_clk_pkg::DIV_4 && new_div != pwr_clk_pkg::DIV_4
      |=> $stable(r.div_sel)) else $error("slow divider changed directly");
   a_switchback_hit: assert property (r.sw_en && switchback
      |=> r.div_sel == pwr_clk_pkg::DIV_4) else $error("switchback missed");
   a_switchback_off: assert property (!r.sw_en && switchback && !wr
      |=> $stable(r.div_sel)) else $error("switchback while disabled");
   a_amp_guard: assert property (wr && idx == pwr_clk_pkg::IDX_POWER_MANAGE
      && wd[pwr_clk_pkg::POS_AMP_OFF] && r.src_sel && !r.amp_off
      |=> !r.amp_off) else $error("amp disabled on crystal");
   a_stop_hold: assert property (clocks_stopped && !stop_wake
      |=> clocks_stopped && !crystal_amp_on && !cif.cycle_en) else $error("stop left early");
   a_idle_exit: assert property (r.mode == pwr_clk_pkg::MODE_IDLE && irq_any
      |=> !cpu_halted) else $error("idle not left on interrupt");
   a_ref_in_stop: assert property (clocks_stopped |-> reference_on == r.ref_stop)
      else $error("reference wrong in stop");
   a_ring_exit: assert property (s_ring_exit |=> s_ring_running)
      else $error("ring wake not immediate");
   a_ring_return: assert property (r.ring_hold && xtal_ready && r.src_eff
      |=> !ring_flag) else $error("crystal not taken back");
   a_div_boundary: assert property ($changed(cif.div_eff) |-> cif.cycle_en)
      else $error("divider changed mid cycle");
   a_strobe_quiet: assert property (r.strobe_sup && !external_data_move
      |=> !addr_strobe) else $error("strobe toggled while suppressed");
   a_status_read: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
      && idx == pwr_clk_pkg::IDX_STATUS |=> wb_ack_o
      && wb_dat_o[7:0] == {$past(level_active), $past(xtal_ready), $past(port_busy)})
      else $error("status read mismatch");
endmodule
`default_nettype wire

// ==== hw/pwr_clk_pkg.sv ====
`default_nettype none
package pwr_clk_pkg;
   // -------------------------------------------------------------
   // register indices, byte address is four times the index
   // -------------------------------------------------------------
   localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
   localparam logic [7:0] IDX_CLOCK_CONTROL = 8'h8E;
   localparam logic [7:0] IDX_EXT_FLAGS     = 8'h91;
   localparam logic [7:0] IDX_POWER_MANAGE  = 8'hC4;
   localparam logic [7:0] IDX_STATUS        = 8'hC5;
   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int POS_IDLE       = 0;
   localparam int POS_STOP       = 1;
   localparam int POS_TMR_LO     = 3;
   localparam int POS_REF_STOP   = 0;
   localparam int POS_RING_WAKE  = 1;
   localparam int POS_RING_FLAG  = 2;
   localparam int POS_SRC_SEL    = 3;
   localparam int POS_STROBE_SUP = 2;
   localparam int POS_AMP_OFF    = 3;
   localparam int POS_SW_EN      = 5;
   localparam int POS_DIV_LO     = 6;
   localparam int POS_XTAL_READY = 4;
   localparam int POS_LEVEL_LO   = 5;
   // -------------------------------------------------------------
   // divider codes, timing counts, reset values
   // -------------------------------------------------------------
   localparam logic [1:0] DIV_4    = 2'h1;
   localparam logic [1:0] DIV_64   = 2'h2;
   localparam logic [1:0] DIV_1024 = 2'h3;
   localparam int CYC_CLKS_4       = 4;
   localparam int CYC_CLKS_64      = 64;
   localparam int CYC_CLKS_1024    = 1024;
   localparam int TIMER_FAST_CLKS  = 4;
   localparam int TIMER_SLOW_CLKS  = 12;
   localparam int STROBE_CLKS      = 4;
   localparam int WARMUP_CLKS      = 65536;
   localparam logic [1:0] RST_DIV_SEL    = DIV_4;
   localparam logic       RST_SRC_SEL    = 1'b1;
   localparam logic       RST_XTAL_READY = 1'b1;
   localparam logic       RST_CLEAR      = 1'b0;

   typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_STOP, MODE_WARM} mode_e;
endpackage
`default_nettype wire

// ==== hw/cycle_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface cycle_if;
   logic [1:0] div_sel;
   logic       hold;
   logic [2:0] tmr_fast;
   logic       cycle_en;
   logic [2:0] timer_tick;
   logic [1:0] div_eff;
   modport ctrl (output div_sel, hold, tmr_fast, input cycle_en, timer_tick, div_eff);
   modport gen  (input div_sel, hold, tmr_fast, output cycle_en, timer_tick, div_eff);
endinterface
`default_nettype wire

// ==== hw/cycle_divider.sv ====
`timescale 1ns/1ns
`default_nettype none
module cycle_divider (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // divider link
   cycle_if.gen     cif
);
   typedef struct packed {
      logic [1:0] div_eff;
      logic [9:0] cnt;
      logic [1:0] third;
      logic       cyc;
   } div_s;

   div_s       r;
   div_s       n;
   logic [9:0] term;

   // -------------------------------------------------------------
   // period counter
   // -------------------------------------------------------------
   always_comb begin
      case (r.div_eff)
         pwr_clk_pkg::DIV_64:   term = 10'(pwr_clk_pkg::CYC_CLKS_64 - 1);
         pwr_clk_pkg::DIV_1024: term = 10'(pwr_clk_pkg::CYC_CLKS_1024 - 1);
         default:               term = 10'(pwr_clk_pkg::CYC_CLKS_4 - 1);
      endcase
      n = r;
      n.cyc = 1'b0;
      if (!cif.hold) begin
         if (r.cnt >= term) begin
            // new selection only lands on a cycle boundary
            n.cnt = 10'h000;
            n.cyc = 1'b1;
            n.div_eff = cif.div_sel;
            n.third = (r.third == 2'(pwr_clk_pkg::TIMER_SLOW_CLKS / pwr_clk_pkg::TIMER_FAST_CLKS - 1))
                      ? 2'h0 : 2'(r.third + 2'h1);
         end else begin
            n.cnt = 10'(r.cnt + 10'h001);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         r <= '{div_eff: pwr_clk_pkg::RST_DIV_SEL, cnt: 10'h000, third: 2'h0, cyc: 1'b0};
      end else begin
         r <= n;
      end
   end

   // -------------------------------------------------------------
   // per-timer rate, slow ticks every third cycle
   // -------------------------------------------------------------
   for (genvar i = 0; i < 3; i++) begin : g_tick
      assign cif.timer_tick[i] = cif.tmr_fast[i] ? r.cyc : (r.cyc && r.third == 2'h0);
   end
   assign cif.cycle_en = r.cyc;
   assign cif.div_eff  = r.div_eff;
endmodule
`default_nettype wire

// ==== hw/warmup_counter.sv ====
`timescale 1ns/1ns
`default_nettype none
module warmup_counter #(
   parameter int unsigned LIMIT = pwr_clk_pkg::WARMUP_CLKS
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic srst,
   // oscillator state
   input  wire logic run,
   output logic      ready
);
   localparam int CW = $clog2(LIMIT + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          ready;
   } warm_s;

   warm_s r;
   warm_s n;

   always_comb begin
      n = r;
      if (!run) begin
         n.cnt   = '0;
         n.ready = 1'b0;
      end else if (!r.ready) begin
         if (r.cnt == CW'(LIMIT - 1)) begin
            n.ready = 1'b1;
         end else begin
            n.cnt = CW'(r.cnt + 1'b1);
         end
      end
   end

   // power-up leaves the crystal already counted as stable
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         r <= '{cnt: '0, ready: pwr_clk_pkg::RST_XTAL_READY};
      end else begin
         r <= n;
      end
   end

   assign ready = r.ready;
endmodule
`default_nettype wire

// ==== testbench/power_clock_management_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module power_clock_management_tb_top;
   // ----------------------------------------
   // stimulus and observation
   // ----------------------------------------
   localparam int WARM = 16;
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [9:0]  wb_adr_i = 10'h000;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic [2:0]  lvl = 3'h0;
   logic [3:0]  busy = 4'h0;
   logic        irq_any = 1'b0;
   logic        wake = 1'b0;
   logic        pfail = 1'b0;
   logic [4:0]  ev = 5'h00;
   logic        xmove = 1'b0;
   logic [2:0]  tick;
   logic        halted;
   logic        stopped;
   logic        ref_on;
   logic        strobe;
   logic        cyc_en;
   logic        ring;
   logic        amp_on;
   logic [7:0]  exp_q[$];
   int          fails = 0;
   int          n_tests = 0;
   int          cycles = 0;
   int          seed = 68;
   int          cnt;
   logic [7:0]  v;
   power_clock_management #(.WARMUP_CLKS(WARM)) uut (
      .clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .level_active(lvl), .port_busy(busy),
      .irq_any(irq_any), .ext_irq_wake(wake), .powerfail_event(pfail),
      .ext_irq_valid(ev[4]), .rx_start_bit(ev[3:2]), .tx_buffer_write(ev[1:0]),
      .external_data_move(xmove), .cpu_cycle_en(cyc_en), .timer_tick(tick),
      .cpu_clk_ring(ring), .crystal_amp_on(amp_on), .reference_on(ref_on), .cpu_halted(halted),
      .clocks_stopped(stopped), .addr_strobe(strobe));
   always #10 clk_sys = ~clk_sys;
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic [7:0] idx, input logic w, input logic [7:0] d);
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= 4'hF;
      wb_dat_i <= {24'h0, d};
      @(posedge clk_sys);
      while (wb_ack_o !== 1'b1) @(posedge clk_sys);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(idx, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      exp_q.push_back(exp);
      xfer(idx, 1'b0, 8'h00);
   endtask
   // clocks from one cycle pulse to the next, phase independent
   task automatic gap(output int p);
      do begin
         @(posedge clk_sys);
      end while (cyc_en !== 1'b1);
      p = 0;
      do begin
         @(posedge clk_sys);
         p++;
      end while (cyc_en !== 1'b1);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // read data is judged where ack is sampled, against the oldest note
   always @(posedge clk_sys) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
         check(wb_dat_o, {24'h0, exp_q.pop_front()});
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles >= 10000) begin
         fails++;
         close_out();
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge clk_sys);
      srst <= 1'b0;
      v = 8'($random(seed));
      lvl <= v[7:5];
      busy <= v[3:0];
      // start on a tick so the window spans whole timer periods
      do begin
         @(posedge clk_sys);
      end while (tick[0] !== 1'b1);
      cnt = 0;
      repeat (120) begin
         @(posedge clk_sys);
         cnt += int'(tick[0] === 1'b1);
      end
      check(cnt, 10);
      gap(cnt);
      check(cnt, 4);
      rd(pwr_clk_pkg::IDX_STATUS, {v[7:5], 1'b1, v[3:0]});
      rd(pwr_clk_pkg::IDX_EXT_FLAGS, 8'h08);
      rd(pwr_clk_pkg::IDX_POWER_MANAGE, 8'h40);
      rd(pwr_clk_pkg::IDX_CLOCK_CONTROL, 8'h00);
      rd(8'h10, 8'h00);
      v = 8'($random(seed));
      wr(pwr_clk_pkg::IDX_CLOCK_CONTROL, v);
      rd(pwr_clk_pkg::IDX_CLOCK_CONTROL, v & 8'h38);
      wr(pwr_clk_pkg::IDX_POWER_MANAGE, 8'h80);
      gap(cnt);
      gap(cnt);
      check(cnt, 64);
      wr(pwr_clk_pkg::IDX_POWER_MANAGE, 8'hC0);
      rd(pwr_clk_pkg::IDX_POWER_MANAGE, 8'h80);
      ev <= 5'h10;
      @(posedge clk_sys);
      ev <= 5'h00;
      rd(pwr_clk_pkg::IDX_POWER_MANAGE, 8'h80);
      // every switchback source, each from the 64-clock mode
      for (int i = 0; i < 5; i++) begin
         wr(pwr_clk_pkg::IDX_POWER_MANAGE, 8'h40);
         wr(pwr_clk_pkg::IDX_POWER_MANAGE, 8'hA0);
         ev <= 5'h01 << i;
         @(posedge clk_sys);
         ev <= 5'h00;
         rd(pwr_clk_pkg::IDX_POWER_MANAGE, 8'h60);
      end
      wr(pwr_clk_pkg::IDX_POWER_MANAGE, 8'hC0);
      gap(cnt);
      gap(cnt);
      check(cnt, 1024);
      wr(pwr_clk_pkg::IDX_POWER_MANAGE, 8'h48);
      rd(pwr_clk_pkg::IDX_POWER_MANAGE, 8'h40);
      wr(pwr_clk_pkg::IDX_EXT_FLAGS, 8'h00);
      gap(cnt);
      gap(cnt);
      rd(pwr_clk_pkg::IDX_EXT_FLAGS, 8'h04);
      check({31'h0, ring}, 32'h1);
      wr(pwr_clk_pkg::IDX_POWER_MANAGE, 8'h4C);
      rd(pwr_clk_pkg::IDX_STATUS, {lvl, 1'b0, busy});
      check({31'h0, amp_on}, 32'h0);
      wr(pwr_clk_pkg::IDX_EXT_FLAGS, 8'h08);
      rd(pwr_clk_pkg::IDX_EXT_FLAGS, 8'h04);
      wr(pwr_clk_pkg::IDX_POWER_MANAGE, 8'h44);
      v = 8'h0;
      repeat (8) begin
         @(posedge clk_sys);
         v[0] = v[0] | strobe;
      end
      check({31'h0, v[0]}, 32'h0);
      xmove <= 1'b1;
      repeat (8) begin
         @(posedge clk_sys);
         v[1] = v[1] | strobe;
      end
      xmove <= 1'b0;
      check({31'h0, v[1]}, 32'h1);
      repeat (WARM + 8) @(posedge clk_sys);
      rd(pwr_clk_pkg::IDX_STATUS, {lvl, 1'b1, busy});
      wr(pwr_clk_pkg::IDX_EXT_FLAGS, 8'h0B);
      gap(cnt);
      gap(cnt);
      rd(pwr_clk_pkg::IDX_EXT_FLAGS, 8'h0B);
      wr(pwr_clk_pkg::IDX_POWER_CONTROL, 8'h02);
      irq_any <= 1'b1;
      repeat (3) @(posedge clk_sys);
      irq_any <= 1'b0;
      check({28'h0, stopped, halted, ref_on, amp_on}, 32'hE);
      wake <= 1'b1;
      @(posedge clk_sys);
      wake <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check({29'h0, stopped, halted, ring}, 32'h1);
      rd(pwr_clk_pkg::IDX_EXT_FLAGS, 8'h0F);
      repeat (WARM + 8) @(posedge clk_sys);
      rd(pwr_clk_pkg::IDX_EXT_FLAGS, 8'h0B);
      check({31'h0, ring}, 32'h0);
      wr(pwr_clk_pkg::IDX_POWER_CONTROL, 8'h01);
      repeat (2) @(posedge clk_sys);
      check({30'h0, stopped, halted}, 32'h1);
      irq_any <= 1'b1;
      repeat (2) @(posedge clk_sys);
      irq_any <= 1'b0;
      check({31'h0, halted}, 32'h0);
      // power-fail wake works while the reference stays on in stop
      wr(pwr_clk_pkg::IDX_POWER_CONTROL, 8'h02);
      pfail <= 1'b1;
      @(posedge clk_sys);
      pfail <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check({29'h0, stopped, halted, ring}, 32'h1);
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      rd(pwr_clk_pkg::IDX_POWER_MANAGE, 8'h40);
      rd(pwr_clk_pkg::IDX_EXT_FLAGS, 8'h08);
      rd(pwr_clk_pkg::IDX_CLOCK_CONTROL, 8'h00);
      close_out();
   end
endmodule
`default_nettype wire
